/* core/cfe_equalizer.sv */
// complex fractionally spaced fir equalizer with sample buffer
// assumes one 40 MHz clock, front end and decision logic on that clock
`timescale 1ns/10ps
`default_nettype none
`include "cfe_params.svh"

module cfe_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int CNT_W = 5
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [CNT_W-2:0] wr_ptr, rd_ptr;
  logic [CNT_W-1:0] count, next_count;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // count and flags are registered so in_ready and out_valid are clean flops
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      count <= next_count;
      in_ready <= (next_count != CNT_W'(DEPTH));
      out_valid <= (next_count != '0);
    end
  end

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // storage carries no reset; it is never read while empty
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module cfe_equalizer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // samples from the front end at twice the symbol rate
  input wire logic sample_valid,
  input wire cfe_pkg::cfe_cplx_type sample_in,
  output logic sample_ready,
  // equalized output at symbol rate
  output logic out_valid,
  output cfe_pkg::cfe_cplx_type out_data,
  // coefficient load, honoured only while busy is low
  input wire logic coef_wr,
  input wire cfe_pkg::cfe_coef_wr_type coef_wr_data,
  // step-scaled error from the decision logic
  input wire logic adapt_valid,
  input wire cfe_pkg::cfe_cplx_type adapt_err,
  // status
  output logic busy
);
  cfe_pkg::cfe_cplx_type sample_line [`CFE_NUM_TAPS], coef_line [`CFE_NUM_TAPS];
  cfe_pkg::cfe_state_type state;
  cfe_pkg::cfe_cplx_type fifo_data, err_hold, x_cur, c_cur;
  logic fifo_valid, fifo_ready, take, decim, adapt_pend, adapt_start, last_tap;
  logic [`CFE_PTR_W-1:0] wr_ptr, rd_ptr, tap;
  logic signed [`CFE_ACC_W-1:0] acc_re, acc_im, next_acc_re, next_acc_im;
  logic signed [`CFE_ACC_W-1:0] upd_re, upd_im;

  // signed 1.15 product widened to the accumulator
  function automatic logic signed [`CFE_ACC_W-1:0] mul(
    input logic signed [`CFE_DATA_W-1:0] a,
    input logic signed [`CFE_DATA_W-1:0] b
  );
    logic signed [2*`CFE_DATA_W-1:0] p;
    p = a * b;
    return `CFE_ACC_W'(p);
  endfunction

  // clip a value already aligned to 1.15 into 16 bits
  function automatic logic signed [`CFE_DATA_W-1:0] sat16(
    input logic signed [`CFE_ACC_W-1:0] v
  );
    logic ovf;
    ovf = (v[`CFE_ACC_W-1:`CFE_DATA_W-1] != {(`CFE_ACC_W-`CFE_DATA_W+1){v[`CFE_DATA_W-1]}});
    if (!ovf) begin
      return v[`CFE_DATA_W-1:0];
    end else if (v[`CFE_ACC_W-1]) begin
      return 16'h8000;
    end else begin
      return 16'h7FFF;
    end
  endfunction

  // buffer absorbs bursts; the sequencer pulls only when idle
  cfe_fifo #(
    .WIDTH(2*`CFE_DATA_W),
    .DEPTH(`CFE_FIFO_DEPTH),
    .CNT_W(`CFE_FIFO_CNT_W)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(sample_valid),
    .in_data(sample_in),
    .in_ready(sample_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_ready)
  );

  // adaptation has priority over a new sample so the line stays aligned
  assign adapt_start = (state == cfe_pkg::CFE_IDLE) && adapt_pend;
  assign fifo_ready = (state == cfe_pkg::CFE_IDLE) && !adapt_pend;
  assign take = fifo_ready && fifo_valid;
  assign last_tap = (tap == `CFE_LAST_TAP);
  assign x_cur = sample_line[rd_ptr];
  assign c_cur = coef_line[tap];

  // complex mac with 1.15 operands
  always_comb begin
    next_acc_re = acc_re + mul(x_cur.re, c_cur.re) - mul(x_cur.im, c_cur.im);
    next_acc_im = acc_im + mul(x_cur.re, c_cur.im) + mul(x_cur.im, c_cur.re);
    if (last_tap) begin
      next_acc_re = next_acc_re + `CFE_ROUND;
      next_acc_im = next_acc_im + `CFE_ROUND;
    end
  end

  // tap step: c += e * conj(x), moving down the squared error slope
  always_comb begin
    upd_re = mul(err_hold.re, x_cur.re) + mul(err_hold.im, x_cur.im);
    upd_im = mul(err_hold.im, x_cur.re) - mul(err_hold.re, x_cur.im);
    upd_re = (upd_re >>> `CFE_FRAC_BITS) + `CFE_ACC_W'(c_cur.re);
    upd_im = (upd_im >>> `CFE_FRAC_BITS) + `CFE_ACC_W'(c_cur.im);
  end

  // sequencer: idle, n tap steps of filtering, or n tap updates
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= cfe_pkg::CFE_IDLE;
      decim <= 1'b0;
      tap <= '0;
      rd_ptr <= '0;
      busy <= 1'b0;
    end else begin
      unique case (state)
        cfe_pkg::CFE_IDLE: begin
          tap <= '0;
          if (adapt_start) begin
            state <= cfe_pkg::CFE_ADAPT;
            rd_ptr <= wr_ptr;
            busy <= 1'b1;
          end else if (take) begin
            decim <= !decim;
            if (decim) begin
              state <= cfe_pkg::CFE_FILT;
              rd_ptr <= wr_ptr + 1'b1; // oldest entry after this write
              busy <= 1'b1;
            end
          end
        end
        cfe_pkg::CFE_FILT, cfe_pkg::CFE_ADAPT: begin
          // wrap back onto the oldest sample and first tap
          rd_ptr <= rd_ptr + 1'b1;
          tap <= tap + 1'b1;
          if (last_tap) begin
            state <= cfe_pkg::CFE_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state <= cfe_pkg::CFE_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // circular delay line, newest overwrites oldest, no feedback path
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      for (int i = 0; i < `CFE_NUM_TAPS; i++) begin
        sample_line[i] <= '0;
      end
    end else if (take) begin
      sample_line[wr_ptr] <= fifo_data;
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // accumulators cleared at the start of each output
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_re <= '0;
      acc_im <= '0;
    end else if (state == cfe_pkg::CFE_FILT && !last_tap) begin
      acc_re <= next_acc_re;
      acc_im <= next_acc_im;
    end else begin
      acc_re <= '0;
      acc_im <= '0;
    end
  end

  // upper word of the rounded sum, clipped if it overflowed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= (state == cfe_pkg::CFE_FILT) && last_tap;
      if (state == cfe_pkg::CFE_FILT && last_tap) begin
        out_data.re <= sat16(next_acc_re >>> `CFE_FRAC_BITS);
        out_data.im <= sat16(next_acc_im >>> `CFE_FRAC_BITS);
      end
    end
  end

  // error capture; a new error in the start cycle is kept pending
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      adapt_pend <= 1'b0;
      err_hold <= '0;
    end else begin
      if (adapt_valid) begin
        adapt_pend <= 1'b1;
        err_hold <= adapt_err;
      end else if (adapt_start) begin
        adapt_pend <= 1'b0;
      end
    end
  end

  // coefficient table: external load when idle, saturating update in adapt
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `CFE_NUM_TAPS; i++) begin
        coef_line[i] <= '0;
      end
    end else if (state == cfe_pkg::CFE_ADAPT) begin
      coef_line[tap].re <= sat16(upd_re);
      coef_line[tap].im <= sat16(upd_im);
    end else if (coef_wr && !busy) begin
      coef_line[coef_wr_data.idx] <= coef_wr_data.val;
    end
  end
endmodule

`default_nettype wire

/* core/cfe_params.svh */
// constants for the complex fractionally spaced equalizer
// assumes inclusion by bare name from the equalizer sources
`ifndef CFE_PARAMS_SVH
`define CFE_PARAMS_SVH

// tap count and pointer width of the circular lines
`define CFE_NUM_TAPS 8
`define CFE_PTR_W 3
`define CFE_LAST_TAP 3'h7
// data format: 1.15 signed
`define CFE_DATA_W 16
`define CFE_FRAC_BITS 15
// accumulator with eight guard bits over a 2.30 product
`define CFE_ACC_W 40
`define CFE_ROUND 40'h0000004000
// sample buffer in front of the delay line
`define CFE_FIFO_DEPTH 16
`define CFE_FIFO_CNT_W 5

`endif

/* core/cfe_pkg.sv */
// types shared by the equalizer, its checker and its bench models
// assumes cfe_params.svh defines the widths
`include "cfe_params.svh"

package cfe_pkg;

  // one complex value in 1.15 format
  typedef struct packed {
    logic signed [`CFE_DATA_W-1:0] re;
    logic signed [`CFE_DATA_W-1:0] im;
  } cfe_cplx_type;

  // coefficient load request
  typedef struct packed {
    logic [`CFE_PTR_W-1:0] idx;
    cfe_cplx_type val;
  } cfe_coef_wr_type;

  // sequencer states
  typedef enum logic [1:0] {
    CFE_IDLE = 2'b00,
    CFE_FILT = 2'b01,
    CFE_ADAPT = 2'b10
  } cfe_state_type;

endpackage

/* test/cfe_checker.sv */
// port checker for the equalizer
// assumes one sys_clk domain, rst_n async active low
`timescale 1ns/10ps
`default_nettype none
module cfe_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // watched signals
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic out_valid,
  input wire cfe_pkg::cfe_cplx_type out_data,
  input wire logic adapt_valid,
  input wire logic busy
);
  int taken;
  int outs;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // sample and result totals; the buffer bounds their gap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      taken <= 0;
      outs <= 0;
    end else begin
      taken <= taken + int'(sample_valid && sample_ready);
      outs <= outs + int'(out_valid);
    end
  end
  chk_strobe_single: assert property (out_valid |=> !out_valid)
    else $error("strobe too long");
  chk_data_held: assert property (!out_valid |-> $stable(out_data))
    else $error("result moved");
  chk_busy_span: assert property ($rose(busy) |-> busy [*8] ##1 !busy)
    else $error("busy span wrong");
  chk_result_end: assert property (out_valid |-> $fell(busy))
    else $error("result off tap end");
  chk_result_gap: assert property (out_valid |=> !out_valid [*8])
    else $error("results too close");
  chk_pair_count: assert property (out_valid |-> taken >= 2 * outs + 2)
    else $error("result too early");
  chk_backlog_cap: assert property (taken <= 2 * outs + 19)
    else $error("result missing");
  chk_adapt_start: assert property (adapt_valid && !busy |-> ##[1:3] busy)
    else $error("adapt idle");
  cover property (out_valid);
  cover property (!sample_ready);
  cover property (adapt_valid ##[1:3] busy);
endmodule
bind cfe_equalizer cfe_checker chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .out_valid(out_valid),
  .out_data(out_data), .adapt_valid(adapt_valid), .busy(busy));
`default_nettype wire

/* test/cfe_front_end.sv */
// front end model: offers queued samples
// assumes the bench fills pending in stream order
`timescale 1ns/10ps
`default_nettype none
module cfe_front_end (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pacing
  input wire logic gaps,
  // sample side
  output logic sample_valid,
  output cfe_pkg::cfe_cplx_type sample_in,
  input wire logic sample_ready
);
  logic [31:0] pending[$];
  int seed = 82;
  // idle lines toggle so a stale value never looks valid
  initial begin
    sample_valid = 1'h0;
    sample_in = 32'h0;
  end
  // hold each offer until taken, random gaps when asked
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_valid <= 1'h0;
    end else if (sample_valid && !sample_ready) begin
      sample_valid <= 1'h1;
    end else if (pending.size() > 0 && (!gaps || $random(seed) % 3 != 0)) begin
      sample_valid <= 1'h1;
      sample_in <= pending.pop_front();
    end else begin
      sample_valid <= 1'h0;
      sample_in <= ~sample_in;
    end
  end
endmodule
`default_nettype wire

/* test/testbench.sv */
// bench: random streams, saturating corner, adapt, refused load
// assumes the equalizer, its bound checker and the front end model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic gaps = 1'h0;
  logic coef_wr = 1'h0;
  logic adapt_valid = 1'h0;
  logic sample_valid, sample_ready, out_valid, busy;
  cfe_pkg::cfe_cplx_type sample_in, out_data;
  cfe_pkg::cfe_cplx_type adapt_err = 32'h0;
  cfe_pkg::cfe_coef_wr_type coef_wr_data = 35'h0;
  int seed = 82;
  int miscompares = 0;
  int samples_checked = 0;
  int nout = 0;
  logic [31:0] hist[$];
  longint cr[8], ci[8];
  always #12.5 sys_clk = ~sys_clk;
  cfe_equalizer uut (.sys_clk(sys_clk), .rst_n(rst_n), .sample_valid(sample_valid),
    .sample_in(sample_in), .sample_ready(sample_ready), .out_valid(out_valid),
    .out_data(out_data), .coef_wr(coef_wr), .coef_wr_data(coef_wr_data),
    .adapt_valid(adapt_valid), .adapt_err(adapt_err), .busy(busy));
  cfe_front_end fe (.sys_clk(sys_clk), .rst_n(rst_n), .gaps(gaps),
    .sample_valid(sample_valid), .sample_in(sample_in), .sample_ready(sample_ready));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // line entry j of result k, oldest at tap 0, zero before the stream
  function automatic longint xs(input int k, input int j, input int h);
    int i = 2 * k - 8 + j;
    if (i < 0) return 0;
    return longint'($signed(hist[i][16*h+:16]));
  endfunction
  // round at the last step, then clamp to 1.15
  function automatic logic [15:0] rs(input longint a);
    a = (a + 16384) >>> 15;
    return a > 32767 ? 16'h7FFF : a < -32768 ? 16'h8000 : 16'(a);
  endfunction
  function automatic logic [31:0] expect_out(input int k);
    longint re = 0;
    longint im = 0;
    for (int j = 0; j < 8; j++) begin
      re += xs(k, j, 1) * cr[j] - xs(k, j, 0) * ci[j];
      im += xs(k, j, 1) * ci[j] + xs(k, j, 0) * cr[j];
    end
    return {rs(re), rs(im)};
  endfunction
  // score each strobed result against the reference sum
  always @(posedge sys_clk) begin
    if (rst_n && out_valid === 1'h1) begin
      nout++;
      check(out_data, expect_out(nout));
    end
  end
  task automatic do_reset();
    rst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    hist.delete();
    nout = 0;
    @(posedge sys_clk);
  endtask
  task automatic load(input bit corner);
    for (int j = 0; j < 8; j++) begin
      cr[j] = corner ? 32767 : $random(seed) >>> 18;
      ci[j] = corner ? 32767 : $random(seed) >>> 18;
      @(posedge sys_clk);
      coef_wr <= 1'h1;
      coef_wr_data <= {3'(j), 16'(cr[j]), 16'(ci[j])};
    end
    @(posedge sys_clk);
    coef_wr <= 1'h0;
  endtask
  task automatic send(input int n);
    logic [31:0] x;
    for (int i = 0; i < n; i++) begin
      x = $random(seed);
      hist.push_back(x);
      fe.pending.push_back(x);
    end
  endtask
  task automatic settle();
    for (int i = 0; i < 4000 && nout * 2 != hist.size(); i++) begin
      @(posedge sys_clk);
    end
    repeat (3) @(posedge sys_clk);
    check(32'(nout), 32'(hist.size() / 2));
  endtask
  // step-scaled error against the line that made result k
  task automatic adapt(input int k);
    logic signed [15:0] er, ei;
    er = 16'($random(seed) >>> 23);
    ei = 16'($random(seed) >>> 23);
    @(posedge sys_clk);
    adapt_valid <= 1'h1;
    adapt_err <= {er, ei};
    @(posedge sys_clk);
    adapt_valid <= 1'h0;
    for (int j = 0; j < 8; j++) begin
      cr[j] += (er * xs(k, j, 1) + ei * xs(k, j, 0)) >>> 15;
      ci[j] += (ei * xs(k, j, 1) - er * xs(k, j, 0)) >>> 15;
    end
    repeat (12) @(posedge sys_clk);
  endtask
  // saturating burst that fills the buffer, then paced random with adapt
  initial begin
    do_reset();
    load(1'h1);
    send(40);
    settle();
    do_reset();
    gaps <= 1'h1;
    load(1'h0);
    send(20);
    settle();
    adapt(10);
    send(20);
    @(posedge sys_clk iff !busy);
    @(posedge sys_clk iff busy);
    // a value no loaded or adapted tap can hold, so a wrongly taken load shows
    coef_wr <= 1'h1;
    coef_wr_data <= {3'h0, 16'h7FFF, 16'h8000};
    @(posedge sys_clk);
    coef_wr <= 1'h0;
    settle();
    results();
  end
  // hang guard well beyond the expected run
  initial begin
    #500000;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
